// ==== design/qbs_pkg.sv ====
// Constants and types shared by the four-word burst SRAM port.
package qbs_pkg;

  // ==========================================================================
  // Word and address geometry
  // ==========================================================================
  localparam int unsigned WORD_W_NARROW = 18;
  localparam int unsigned WORD_W_WIDE   = 36;
  localparam int unsigned ADDR_W_NARROW = 7;
  localparam int unsigned ADDR_W_WIDE   = 6;
  localparam int unsigned BURST_LEN     = 4;
  localparam int unsigned BURST_IDX_W   = 2;

  // ==========================================================================
  // Read latency, counted in clock edges (K and K complement alternate)
  // ==========================================================================
  localparam logic [2:0] LAT_EDGES_LONG  = 3'h4;
  localparam logic [2:0] LAT_EDGES_SHORT = 3'h2;
  localparam int unsigned READ_AGES      = 7;

  // ==========================================================================
  // Values after reset
  // ==========================================================================
  localparam logic       RST_SLOT     = 1'b0;
  localparam logic       RST_EDGE_REF = 1'b1;
  localparam logic [3:0] RST_AGE_CNT  = 4'hf;

  typedef enum logic [0:0] {
    QBS_WR_IDLE  = 1'b0,
    QBS_WR_BURST = 1'b1
  } qbs_wr_state_t;

endpackage : qbs_pkg

// ==== design/qbs_sram_port.sv ====
// Four-word burst double-data-rate SRAM port with split read/write ports.
`timescale 1ns/1ps
// ============================================================================
// What this block does
// - Read and write ports run independently, concurrently.
// - Shared address bus, read/write on alternate K edges.
// - Each address moves a burst of four words.
// - One word per K and K-complement rising edge.
// - Only rising edges of both clocks are used.
// - Mode high gives read latency of two cycles.
// - Mode low gives read latency of one cycle.
// - All inputs captured in clock-edge input registers.
// - Read data driven from edge-clocked output registers.
// - Writes complete by internal self-timed sequencing.
// - Valid flag marks periods holding read data.
// - Echo clock pair output, aligned with read data.
// - Port selects gate each port; inactive port ignored.
// - Reads return newest data, even in-flight writes.
// - Word width 18 or 36, depth scales to match.
// ============================================================================
module qbs_sram_port #(
  parameter bit WIDE_WORDS = 1'b1,
  localparam int unsigned DW = WIDE_WORDS ? qbs_pkg::WORD_W_WIDE
                                          : qbs_pkg::WORD_W_NARROW,
  localparam int unsigned AW = WIDE_WORDS ? qbs_pkg::ADDR_W_WIDE
                                          : qbs_pkg::ADDR_W_NARROW
) (
  input  wire logic                    clk_in,
  input  wire logic                    reset_n_in,
  input  wire logic                    k_clk_in,
  input  wire logic                    k_clk_n_in,
  input  wire logic                    latency_mode_select_in,
  input  wire logic                    read_sel_n_in,
  input  wire logic                    write_sel_n_in,
  input  wire logic [AW-1:0]           addr_in,
  input  wire logic [DW-1:0]           wr_data_in,
  output logic      [DW-1:0]           rd_data_out,
  output logic                         read_valid_flag_out,
  output logic                         echo_clock_out,
  output logic                         echo_clock_n_out
);

  localparam int unsigned MW = AW + qbs_pkg::BURST_IDX_W;
  localparam int unsigned NA = qbs_pkg::READ_AGES;
  localparam int unsigned SW = 5 + AW + DW;
  // Synchronisers start at the pins' idle levels, so no false edge follows.
  localparam logic [SW-1:0] SYNC_RST = {1'b0, qbs_pkg::RST_EDGE_REF, 3'h3,
                                        {(AW+DW){1'b0}}};

  // ==========================================================================
  // Reset release and input synchronisers
  // ==========================================================================
  logic          rst_s1_q;
  logic          rst_n;
  logic [SW-1:0] in_raw;
  logic [SW-1:0] in_s1_q;
  logic [SW-1:0] in_s2_q;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  assign in_raw = {k_clk_in, k_clk_n_in, latency_mode_select_in,
                   read_sel_n_in, write_sel_n_in, addr_in, wr_data_in};

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      in_s1_q <= SYNC_RST;
      in_s2_q <= SYNC_RST;
    end else begin
      in_s1_q <= in_raw;
      in_s2_q <= in_s1_q;
    end
  end
  logic          k_s;
  logic          kn_s;
  logic          mode_s;
  logic          rsel_n_s;
  logic          wsel_n_s;
  logic [AW-1:0] addr_s;
  logic [DW-1:0] wdata_s;

  assign {k_s, kn_s, mode_s, rsel_n_s, wsel_n_s, addr_s, wdata_s} = in_s2_q;

  // ==========================================================================
  // Rising edge detection on both input clocks
  // ==========================================================================
  logic k_d_q;
  logic kn_d_q;
  logic k_rise;
  logic edge_evt;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      k_d_q  <= qbs_pkg::RST_EDGE_REF;
      kn_d_q <= qbs_pkg::RST_EDGE_REF;
    end else begin
      k_d_q  <= k_s;
      kn_d_q <= kn_s;
    end
  end

  assign k_rise   = k_s & ~k_d_q;
  assign edge_evt = k_rise | (kn_s & ~kn_d_q);

  // ==========================================================================
  // Memory array
  // ==========================================================================
  logic [DW-1:0] mem_q [2**MW];
  logic          mem_we;
  logic [MW-1:0] mem_wa;
  logic [DW-1:0] mem_wd;

  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  // ==========================================================================
  // Address slots, write sequencer and read pipeline
  // ==========================================================================
  logic                   slot_q, slot_d;
  qbs_pkg::qbs_wr_state_t wr_state_q, wr_state_d;
  logic [1:0]             wr_idx_q, wr_idx_d;
  logic [AW-1:0]          wr_addr_q, wr_addr_d;
  logic [NA-1:0]          rv_q, rv_d;
  logic [AW-1:0]          ra_q [NA];
  logic [AW-1:0]          ra_d [NA];
  logic [DW-1:0]          rd_data_q, rd_data_d;
  logic [1:0]             rd_word_q, rd_word_d;
  logic                   valid_q, valid_d;
  logic                   echo_q, echo_n_q;
  logic                   rd_take;
  logic                   wr_take;
  logic                   hit;
  logic [2:0]             lat;
  logic [MW-1:0]          rd_idx;

  always_comb begin
    int age;
    age        = 0;
    slot_d     = slot_q;
    wr_state_d = wr_state_q;
    wr_idx_d   = wr_idx_q;
    wr_addr_d  = wr_addr_q;
    rv_d       = rv_q;
    ra_d       = ra_q;
    rd_data_d  = rd_data_q;
    rd_word_d  = rd_word_q;
    valid_d    = valid_q;
    hit        = 1'b0;
    rd_idx     = '0;
    // Read slot on even K edges, write slot on odd ones.
    rd_take    = k_rise && !slot_q && !rsel_n_s;
    wr_take    = k_rise && slot_q && !wsel_n_s;
    mem_we     = 1'b0;
    mem_wa     = {wr_addr_q, wr_idx_q};
    mem_wd     = wdata_s;
    if (k_rise) begin
      slot_d = ~slot_q;
    end
    case (wr_state_q)
      qbs_pkg::QBS_WR_IDLE: begin
        if (wr_take) begin
          mem_we     = 1'b1;
          mem_wa     = {addr_s, 2'h0};
          wr_addr_d  = addr_s;
          wr_idx_d   = 2'h1;
          wr_state_d = qbs_pkg::QBS_WR_BURST;
        end
      end
      qbs_pkg::QBS_WR_BURST: begin
        if (edge_evt) begin
          mem_we   = 1'b1;
          wr_idx_d = wr_idx_q + 2'h1;
          if (wr_idx_q == 2'h3) begin
            wr_state_d = qbs_pkg::QBS_WR_IDLE;
          end
        end
      end
      default: wr_state_d = qbs_pkg::QBS_WR_IDLE;
    endcase
    lat = mode_s ? qbs_pkg::LAT_EDGES_LONG
                 : qbs_pkg::LAT_EDGES_SHORT;
    for (int i = 0; i < NA; i++) begin
      age = i + 1 - int'(lat);
      if (rv_q[i] && age >= 0 && age < int'(qbs_pkg::BURST_LEN)) begin
        hit    = 1'b1;
        rd_idx = {ra_q[i], 2'(age)};
      end
    end
    if (edge_evt) begin
      rv_d[0] = rd_take;
      ra_d[0] = addr_s;
      for (int i = 1; i < NA; i++) begin
        rv_d[i] = rv_q[i-1];
        ra_d[i] = ra_q[i-1];
      end
      valid_d = hit;
      if (hit) begin
        rd_word_d = rd_idx[1:0];
        // A word being written this very cycle is forwarded.
        rd_data_d = (mem_we && mem_wa == rd_idx) ? mem_wd
                                                 : mem_q[rd_idx];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      slot_q     <= qbs_pkg::RST_SLOT;
      wr_state_q <= qbs_pkg::QBS_WR_IDLE;
      wr_idx_q   <= '0;
      wr_addr_q  <= '0;
      rv_q       <= '0;
      ra_q       <= '{default: '0};
      rd_data_q  <= '0;
      rd_word_q  <= '0;
      valid_q    <= 1'b0;
      echo_q     <= 1'b0;
      echo_n_q   <= 1'b0;
    end else begin
      slot_q     <= slot_d;
      wr_state_q <= wr_state_d;
      wr_idx_q   <= wr_idx_d;
      wr_addr_q  <= wr_addr_d;
      rv_q       <= rv_d;
      ra_q       <= ra_d;
      rd_data_q  <= rd_data_d;
      rd_word_q  <= rd_word_d;
      valid_q    <= valid_d;
      echo_q     <= k_s;
      echo_n_q   <= kn_s;
    end
  end

  assign rd_data_out         = rd_data_q;
  assign read_valid_flag_out = valid_q;
  assign echo_clock_out      = echo_q;
  assign echo_clock_n_out    = echo_n_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  logic [3:0] hc_q, hc_d;
  logic       seen_q;

  always_comb begin
    hc_d = hc_q;
    if (rd_take) begin
      hc_d = 4'h0;
    end else if (edge_evt && hc_q != 4'hf) begin
      hc_d = hc_q + 4'h1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      hc_q   <= qbs_pkg::RST_AGE_CNT;
      seen_q <= 1'b0;
    end else begin
      hc_q   <= hc_d;
      seen_q <= seen_q | rd_take;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  property p_lat_long;
    edge_evt && mode_s && seen_q && hc_q == 4'h3
      |=> read_valid_flag_out && rd_word_q == 2'h0;
  endproperty
  a_lat_long: assert property (p_lat_long)
    else $error("Long latency read did not start on time.");

  property p_lat_short;
    edge_evt && !mode_s && seen_q && hc_q == 4'h1
      |=> read_valid_flag_out && rd_word_q == 2'h0;
  endproperty
  a_lat_short: assert property (p_lat_short)
    else $error("Short latency read did not start on time.");

  property p_burst_start;
    $rose(read_valid_flag_out) |-> rd_word_q == 2'h0;
  endproperty
  a_burst_start: assert property (p_burst_start)
    else $error("Read burst began on a word other than the first.");

  property p_valid_edge;
    $changed(read_valid_flag_out) |-> $past(edge_evt);
  endproperty
  a_valid_edge: assert property (p_valid_edge)
    else $error("Valid flag changed away from a clock edge.");

  property p_echo_align;
    $rose(read_valid_flag_out) |-> $rose(echo_clock_out)
                                   || $rose(echo_clock_n_out);
  endproperty
  a_echo_align: assert property (p_echo_align)
    else $error("Read data not aligned with an echo clock edge.");

  property p_data_edge;
    $changed(rd_data_out) |-> $past(edge_evt, 1);
  endproperty
  a_data_edge: assert property (p_data_edge)
    else $error("Read data changed away from a clock edge.");

  property p_deselect;
    k_rise && !slot_q && rsel_n_s |=> !rv_q[0];
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("Read taken while its port was deselected.");

  property p_alternate;
    !(rd_take && wr_take);
  endproperty
  a_alternate: assert property (p_alternate)
    else $error("Read and write address taken on one edge.");

  property p_write_end;
    edge_evt && wr_state_q == qbs_pkg::QBS_WR_BURST && wr_idx_q == 2'h3
      |=> wr_state_q == qbs_pkg::QBS_WR_IDLE;
  endproperty
  a_write_end: assert property (p_write_end)
    else $error("Write burst did not end after four words.");

  property p_coherent;
    mem_we |=> mem_q[$past(mem_wa)] == $past(mem_wd);
  endproperty
  a_coherent: assert property (p_coherent)
    else $error("Written word not visible to the next read.");

endmodule // qbs_sram_port

// ==== test/qbs_ctrl_model.sv ====
// Behavioural memory controller driving the burst SRAM port.
`timescale 1ns/1ps
module qbs_ctrl_model #(
  parameter int unsigned AB = 6,
  parameter int unsigned WB = 36
) (
  input  wire logic          clk_in,
  output logic               k_clk_out,
  output logic               k_clk_n_out,
  output logic               read_sel_n_out,
  output logic               write_sel_n_out,
  output logic [AB-1:0]      addr_out,
  output logic [WB-1:0]      wr_data_out
);
  logic [WB-1:0] pend_q [2];

  initial begin
    k_clk_out = 1'b0;
    k_clk_n_out = 1'b1;
    read_sel_n_out = 1'b1;
    write_sel_n_out = 1'b1;
    addr_out = '0;
    wr_data_out = '0;
    pend_q[0] = '0;
    pend_q[1] = '1;
  end

  // ====
  // Inputs settle two cycles before each edge and hold two after it.
  task automatic half(input logic is_k, input logic rs_n, input logic ws_n,
                      input logic [AB-1:0] a, input logic [WB-1:0] d);
    @(posedge clk_in);
    read_sel_n_out <= rs_n;
    write_sel_n_out <= ws_n;
    addr_out <= a;
    wr_data_out <= d;
    repeat (2) @(posedge clk_in);
    k_clk_out <= is_k;
    k_clk_n_out <= ~is_k;
    @(posedge clk_in);
  endtask

  // One read slot and one write slot; words 2 and 3 spill into the next.
  task automatic frame(input logic rd_n, input logic [AB-1:0] ra,
                       input logic wr_n, input logic [AB-1:0] wa,
                       input logic [WB-1:0] w [4]);
    half(1'b1, rd_n, 1'b1, ra, pend_q[0]);
    half(1'b0, 1'b1, 1'b1, ~ra, pend_q[1]);
    half(1'b1, 1'b1, wr_n, wa, w[0]);
    half(1'b0, 1'b1, 1'b1, ~wa, w[1]);
    pend_q[0] = w[2];
    pend_q[1] = w[3];
  endtask
endmodule // qbs_ctrl_model

// ==== test/tb_qbs_sram_port.sv ====
// Self-checking testbench for the burst SRAM port.
`timescale 1ns/1ps
module tb_qbs_sram_port;
  localparam int unsigned AD = qbs_pkg::ADDR_W_WIDE;
  localparam int unsigned WD = qbs_pkg::WORD_W_WIDE;
  typedef struct { int idx; logic [WD-1:0] w; } qbs_exp_t;

  logic          clk_in = 1'b0;
  logic          reset_n_in = 1'b0;
  logic          lat_mode = 1'b1;
  logic          k_clk, k_clk_n, rd_sel_n, wr_sel_n;
  logic [AD-1:0] addr;
  logic [WD-1:0] wr_data, rd_data;
  logic          valid, echo, echo_n;
  logic [WD-1:0] mem [2**(AD+2)];
  qbs_exp_t      exp_q [$];
  int            half_no = 0;
  int            edge_cnt = 0;
  int            compares = 0;
  int            mismatches = 0;

  always #10 clk_in = ~clk_in;

  qbs_sram_port #(.WIDE_WORDS(1'b1)) i_dut (
    .clk_in                 (clk_in),
    .reset_n_in             (reset_n_in),
    .k_clk_in               (k_clk),
    .k_clk_n_in             (k_clk_n),
    .latency_mode_select_in (lat_mode),
    .read_sel_n_in          (rd_sel_n),
    .write_sel_n_in         (wr_sel_n),
    .addr_in                (addr),
    .wr_data_in             (wr_data),
    .rd_data_out            (rd_data),
    .read_valid_flag_out    (valid),
    .echo_clock_out         (echo),
    .echo_clock_n_out       (echo_n)
  );

  qbs_ctrl_model #(.AB(AD), .WB(WD)) i_ctrl (
    .clk_in          (clk_in),
    .k_clk_out       (k_clk),
    .k_clk_n_out     (k_clk_n),
    .read_sel_n_out  (rd_sel_n),
    .write_sel_n_out (wr_sel_n),
    .addr_out        (addr),
    .wr_data_out     (wr_data)
  );

  // ====
  task automatic cmp_word(input string n, input logic [WD-1:0] e,
                          input logic [WD-1:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected=%h seen=%h", n, e, g);
    end
  endtask

  task automatic cmp_bit(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected=%b seen=%b", n, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Each edge's launch is looked at mid-way through the word it launches.
  task automatic check_half(input int j);
    logic ev;
    repeat (6) @(negedge clk_in);
    ev = (exp_q.size() > 0) && (exp_q[0].idx == j);
    cmp_bit("read_valid_flag", ev, valid);
    cmp_bit("echo_clock", ~j[0], echo);
    cmp_bit("echo_clock_n", j[0], echo_n);
    if (ev) begin
      cmp_word("rd_data", exp_q[0].w, rd_data);
      void'(exp_q.pop_front());
    end
  endtask

  always @(posedge k_clk or posedge k_clk_n) begin
    automatic int j = edge_cnt;
    // The X to 1 step of the idle complement clock at start is no edge.
    if (reset_n_in) begin
      edge_cnt++;
      fork
        check_half(j);
      join_none
    end
  end

  // ====
  task automatic do_frame(input logic rd_n, input logic [AD-1:0] ra,
                          input logic wr_n, input logic [AD-1:0] wa);
    logic [WD-1:0] w [4];
    int lat;
    lat = lat_mode ? 4 : 2;
    for (int i = 0; i < 4; i++) begin
      w[i] = WD'({$urandom(), $urandom()});
      if (!wr_n) mem[{wa, i[1:0]}] = w[i];
    end
    for (int i = 0; i < 4 && !rd_n; i++) begin
      exp_q.push_back('{idx: half_no + lat + i, w: mem[{ra, i[1:0]}]});
    end
    half_no += 4;
    i_ctrl.frame(rd_n, ra, wr_n, wa, w);
  endtask

  task automatic run_random(input int n);
    logic [AD-1:0] ra, wa;
    for (int f = 0; f < n; f++) begin
      ra = AD'($urandom());
      wa = (f % 8 == 0) ? ra : AD'($urandom());
      do_frame(($urandom() % 4) == 0, ra, ($urandom() % 4) == 0, wa);
    end
    for (int f = 0; f < 3; f++) begin
      do_frame(1'b1, '0, 1'b1, '0);
    end
  endtask

  initial begin
    void'($urandom(32'h9231));
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    for (int a = 0; a < 2**AD; a++) begin
      do_frame(1'b1, '0, 1'b0, AD'(a));
    end
    $display("test prefill done");
    run_random(150);
    $display("test long latency done");
    lat_mode <= 1'b0;
    @(posedge clk_in);
    run_random(150);
    $display("test short latency done");
    repeat (20) @(posedge clk_in);
    give_verdict();
  end

  initial begin
    repeat (30000) @(posedge clk_in);
    mismatches++;
    $display("[FAIL] run_end expected=done seen=timeout");
    give_verdict();
  end
endmodule // tb_qbs_sram_port
